// ===== mcju_consts.svh
// constants for the microcore conditional jump unit
// Operation
// - control-bit relative jump taken when selected bit matches polarity
// - relative target is the jump instruction address plus offset
// - offset is 5-bit two's complement, reach -16 to 15
// - control bit selector 0000 picks bit 0, 1111 picks bit 15
// - control bit tested in one of the four microcore control registers, picked by the cfg register
// - polarity 0 true on zero bit, polarity 1 true on one bit
// - absolute feedback jump loads counter from selected jump register
// - jump register operand picks one register; any code address reachable
// - relative feedback jump goes to instruction address plus offset
// - feedback codes 0-9 alternate high-side vds and source, drivers 1-5
// - feedback codes 10-15 pick low-side vds feedback of drivers 1-6
// - absolute feedback jump encoding 001110, sel, pol, jreg, 0100
// - relative feedback jump encoding 000101, sel, pol, offset
`ifndef MCJU_CONSTS_SVH
`define MCJU_CONSTS_SVH

`define MCJU_PC_W        10
`define MCJU_DATA_W      16
`define MCJU_PADDR_W     12
`define MCJU_IDX_W       10
`define MCJU_IDX_CFG     10'h000
`define MCJU_IDX_PC      10'h001
`define MCJU_IDX_UC0     10'h101
`define MCJU_IDX_UC1     10'h102
`define MCJU_IDX_UC0B    10'h121
`define MCJU_IDX_UC1B    10'h122
`define MCJU_CTRL_RST    16'h0000
`define MCJU_PC_RST      10'h000
`define MCJU_CFG_RST     2'h0
`define MCJU_PC_STEP     10'h001
`define MCJU_OP_HI       15
`define MCJU_OP_LO       10
`define MCJU_OP_FBF      6'h0E
`define MCJU_OP_FBR      6'h05
`define MCJU_OP_CRR      6'h08
`define MCJU_FBF_TAIL    4'h4
`define MCJU_OFS_HI      4
`define MCJU_OFS_LO      0
`define MCJU_FB_SEL_HI   9
`define MCJU_FB_SEL_LO   6
`define MCJU_FB_POL      5
`define MCJU_FB_JREG     4
`define MCJU_CR_POL      9
`define MCJU_CR_SEL_HI   8
`define MCJU_CR_SEL_LO   5
`define MCJU_TAIL_HI     3
`define MCJU_TAIL_LO     0

`endif

// ===== mcju_pkg.sv
// types for the microcore conditional jump unit
`include "mcju_consts.svh"
package mcju_pkg;
    typedef logic [`MCJU_PC_W-1:0]    mcju_pc_t;
    typedef logic [`MCJU_DATA_W-1:0]  mcju_word_t;
    typedef logic [`MCJU_PADDR_W-1:0] mcju_addr_t;
    typedef enum logic [1:0] {
        MCJU_KIND_NONE = 2'b00,
        MCJU_KIND_CRR  = 2'b01,
        MCJU_KIND_FBF  = 2'b10,
        MCJU_KIND_FBR  = 2'b11
    } mcju_kind_t;
endpackage

// ===== mcju_if.sv
// decoded fields and results passed between the jump unit modules
`timescale 1ns/1ps
interface mcju_if;
    import mcju_pkg::*;
    mcju_kind_t kind;
    mcju_word_t ctrl_word;
    mcju_word_t feedback;
    logic [3:0] selector;
    logic       polarity;
    logic [4:0] offset;
    logic       jreg_idx;
    mcju_pc_t   jreg0;
    mcju_pc_t   jreg1;
    mcju_pc_t   instr_addr;
    logic       cond_met;
    mcju_pc_t   target;
    modport top  (output kind, ctrl_word, feedback, selector, polarity, offset, jreg_idx,
                  jreg0, jreg1, instr_addr, input cond_met, target);
    modport cond (input kind, ctrl_word, feedback, selector, polarity, output cond_met);
    modport tgt  (input kind, offset, jreg_idx, jreg0, jreg1, instr_addr, output target);
endinterface

// ===== mcju_cond.sv
// condition evaluation: bit selection and polarity match
`timescale 1ns/1ps
module mcju_cond (
    mcju_if.cond dec
);
    import mcju_pkg::*;
    logic sel_bit;
    always_comb begin
        if (dec.kind == MCJU_KIND_CRR) begin
            sel_bit = dec.ctrl_word[dec.selector];
        end else begin
            sel_bit = dec.feedback[dec.selector];
        end
    end
    assign dec.cond_met = (dec.kind != MCJU_KIND_NONE) && (sel_bit == dec.polarity);
endmodule // mcju_cond

// ===== mcju_target.sv
// jump destination: jump register or instruction address plus offset
`timescale 1ns/1ps
module mcju_target (
    mcju_if.tgt dec
);
    import mcju_pkg::*;
    mcju_pc_t ofs_ext;
    assign ofs_ext = {{(`MCJU_PC_W-5){dec.offset[4]}}, dec.offset};
    always_comb begin
        if (dec.kind == MCJU_KIND_FBF) begin
            dec.target = dec.jreg_idx ? dec.jreg1 : dec.jreg0;
        end else begin
            dec.target = dec.instr_addr + ofs_ext;
        end
    end
endmodule // mcju_target

// ===== mcju_top.sv
// conditional jump unit top: decode, program counter and apb registers
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module mcju_top (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire mcju_pkg::mcju_addr_t paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               instr_valid,
    input  wire mcju_pkg::mcju_word_t instr_word,
    input  wire mcju_pkg::mcju_word_t predriver_feedback,
    input  wire mcju_pkg::mcju_pc_t jump_register_set0,
    input  wire mcju_pkg::mcju_pc_t jump_register_set1,
    output mcju_pkg::mcju_pc_t      micro_program_counter,
    output logic                    jump_taken
);
    import mcju_pkg::*;

    mcju_if dec ();

    mcju_word_t ctrl_reg [4];
    mcju_word_t ctrl_next [4];
    logic [1:0] cfg_reg;
    logic [1:0] cfg_next;
    mcju_pc_t   pc_reg;
    mcju_pc_t   pc_next;
    logic       taken_reg;
    logic       taken_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic       pready_reg;
    logic       pready_next;
    logic       pslverr_reg;
    logic       pslverr_next;

    logic [`MCJU_IDX_W-1:0] idx;
    logic       aligned;
    logic       setup;
    logic       wr_do;
    logic       hit_cfg;
    logic       hit_pc;
    logic [3:0] hit_ctrl;
    logic       mapped;
    logic [`MCJU_IDX_W-1:0] ctrl_idx [4];
    logic [5:0] opcode;

    assign ctrl_idx[0] = `MCJU_IDX_UC0;
    assign ctrl_idx[1] = `MCJU_IDX_UC1;
    assign ctrl_idx[2] = `MCJU_IDX_UC0B;
    assign ctrl_idx[3] = `MCJU_IDX_UC1B;

    // bus decode
    assign idx     = paddr[`MCJU_PADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign wr_do   = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign hit_cfg = aligned && (idx == `MCJU_IDX_CFG);
    assign hit_pc  = aligned && (idx == `MCJU_IDX_PC);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ctrl
            assign hit_ctrl[gi] = aligned && (idx == ctrl_idx[gi]);
            always_comb begin
                ctrl_next[gi] = ctrl_reg[gi];
                if (wr_do && hit_ctrl[gi]) begin
                    ctrl_next[gi] = pwdata[`MCJU_DATA_W-1:0];
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    ctrl_reg[gi] <= `MCJU_CTRL_RST;
                end else begin
                    ctrl_reg[gi] <= ctrl_next[gi];
                end
            end
        end
    endgenerate

    assign mapped = hit_cfg || hit_pc || (|hit_ctrl);

    // apb answer, zero wait states
    always_comb begin
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        prdata_next  = 32'h0000_0000;
        cfg_next     = cfg_reg;
        if (setup) begin
            pready_next  = 1'b1;
            pslverr_next = !mapped;
            if (!pwrite) begin
                if (hit_cfg) begin
                    prdata_next = {30'h0000_0000, cfg_reg};
                end else if (hit_pc) begin
                    prdata_next = {22'h00_0000, pc_reg};
                end else begin
                    for (int i = 0; i < 4; i++) begin
                        if (hit_ctrl[i]) begin
                            prdata_next = {16'h0000, ctrl_reg[i]};
                        end
                    end
                end
            end
        end
        if (wr_do && hit_cfg) begin
            cfg_next = pwdata[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            cfg_reg     <= `MCJU_CFG_RST;
        end else begin
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
            cfg_reg     <= cfg_next;
        end
    end

    // instruction decode
    assign opcode = instr_word[`MCJU_OP_HI:`MCJU_OP_LO];
    always_comb begin
        dec.kind     = MCJU_KIND_NONE;
        dec.selector = instr_word[`MCJU_FB_SEL_HI:`MCJU_FB_SEL_LO];
        dec.polarity = instr_word[`MCJU_FB_POL];
        if (instr_valid) begin
            if (opcode == `MCJU_OP_FBF
                && instr_word[`MCJU_TAIL_HI:`MCJU_TAIL_LO] == `MCJU_FBF_TAIL) begin
                dec.kind = MCJU_KIND_FBF;
            end else if (opcode == `MCJU_OP_FBR) begin
                dec.kind = MCJU_KIND_FBR;
            end else if (opcode == `MCJU_OP_CRR) begin
                dec.kind     = MCJU_KIND_CRR;
                dec.selector = instr_word[`MCJU_CR_SEL_HI:`MCJU_CR_SEL_LO];
                dec.polarity = instr_word[`MCJU_CR_POL];
            end
        end
    end

    assign dec.ctrl_word  = ctrl_reg[cfg_reg];
    assign dec.feedback   = predriver_feedback;
    assign dec.offset     = instr_word[`MCJU_OFS_HI:`MCJU_OFS_LO];
    assign dec.jreg_idx   = instr_word[`MCJU_FB_JREG];
    assign dec.jreg0      = jump_register_set0;
    assign dec.jreg1      = jump_register_set1;
    assign dec.instr_addr = pc_reg;

    mcju_cond u_cond (
        .dec (dec.cond)
    );

    mcju_target u_target (
        .dec (dec.tgt)
    );

    // program counter update
    always_comb begin
        pc_next    = pc_reg;
        taken_next = 1'b0;
        if (instr_valid) begin
            if (dec.cond_met) begin
                pc_next    = dec.target;
                taken_next = 1'b1;
            end else begin
                pc_next = pc_reg + `MCJU_PC_STEP;
            end
        end
        if (wr_do && hit_pc) begin
            pc_next = pwdata[`MCJU_PC_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_reg    <= `MCJU_PC_RST;
            taken_reg <= 1'b0;
        end else begin
            pc_reg    <= pc_next;
            taken_reg <= taken_next;
        end
    end

    assign micro_program_counter = pc_reg;
    assign jump_taken            = taken_reg;
    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
endmodule // mcju_top

// ===== mcju_assertions.sv
// checker bound to the jump unit top
`timescale 1ns/1ps
module mcju_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire mcju_pkg::mcju_addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_valid,
    input wire mcju_pkg::mcju_word_t instr_word,
    input wire mcju_pkg::mcju_word_t predriver_feedback,
    input wire mcju_pkg::mcju_pc_t jump_register_set0,
    input wire mcju_pkg::mcju_pc_t jump_register_set1,
    input wire mcju_pkg::mcju_pc_t micro_program_counter,
    input wire logic jump_taken
);
    import mcju_pkg::*;
    logic       pcw, hit, ex, fbf;
    logic [5:0] op;
    mcju_pc_t   ofs, jr, pc;
    assign pcw = psel && penable && pwrite && paddr == 12'h004;
    assign op = instr_word[15:10];
    assign hit = predriver_feedback[instr_word[9:6]] == instr_word[5];
    assign ex = instr_valid && !pcw;
    assign fbf = op == 6'h0E && instr_word[3:0] == 4'h4;
    assign ofs = {{5{instr_word[4]}}, instr_word[4:0]};
    assign jr = instr_word[4] ? jump_register_set1 : jump_register_set0;
    assign pc = micro_program_counter;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_fbr_jump; ex && op == 6'h05 && hit |=> jump_taken && pc == $past(pc) + $past(ofs);
    endproperty
    a_fbr_jump: assert property (p_fbr_jump) else $error("fbr jump wrong");
    property p_fbr_stay; ex && op == 6'h05 && !hit |=> !jump_taken && pc == $past(pc) + 10'h001;
    endproperty
    a_fbr_stay: assert property (p_fbr_stay) else $error("fbr step wrong");
    property p_fbf_jump; ex && fbf && hit |=> jump_taken && pc == $past(jr); endproperty
    a_fbf_jump: assert property (p_fbf_jump) else $error("fbf jump wrong");
    property p_fbf_stay; ex && fbf && !hit |=> !jump_taken && pc == $past(pc) + 10'h001;
    endproperty
    a_fbf_stay: assert property (p_fbf_stay) else $error("fbf step wrong");
    property p_fbf_tail; ex && op == 6'h0E && !fbf |=> !jump_taken && pc == $past(pc) + 10'h001;
    endproperty
    a_fbf_tail: assert property (p_fbf_tail) else $error("bad tail jumped");
    property p_crr_step; ex && op == 6'h08 |=> pc == $past(pc) + (jump_taken ? $past(ofs) : 10'h001);
    endproperty
    a_crr_step: assert property (p_crr_step) else $error("crr target wrong");
    property p_hold; !instr_valid && !pcw |=> $stable(pc) && !jump_taken; endproperty
    a_hold: assert property (p_hold) else $error("pc moved while idle");
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong");
    property p_err; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("misaligned not refused");
endmodule // mcju_assertions
bind mcju_top mcju_assertions mcju_assertions_i (.core_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word, .predriver_feedback,
    .jump_register_set0, .jump_register_set1, .micro_program_counter, .jump_taken);

// ===== mcju_partner.sv
// code ram fetch and jump registers model
`timescale 1ns/1ps
module mcju_partner (
    input  wire mcju_pkg::mcju_pc_t pc,
    output mcju_pkg::mcju_word_t    instr_word,
    output mcju_pkg::mcju_pc_t      jreg0,
    output mcju_pkg::mcju_pc_t      jreg1
);
    import mcju_pkg::*;
    mcju_word_t code_ram [1024];
    mcju_pc_t   jregs [2];
    assign instr_word = code_ram[pc];
    assign jreg0 = jregs[0];
    assign jreg1 = jregs[1];
endmodule // mcju_partner

// ===== mcju_tb.sv
// self-checking bench for the conditional jump unit
`timescale 1ns/1ps
module mcju_tb;
    import mcju_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, instr_valid, pready, pslverr, jump_taken;
    logic [31:0] pwdata, prdata, d;
    logic [1:0]  cfg;
    logic [15:0] ctrl [4];
    logic [32:0] qa [$];
    logic [10:0] qi [$];
    mcju_addr_t  paddr;
    mcju_addr_t  ra [4] = '{12'h404, 12'h408, 12'h484, 12'h488};
    mcju_word_t  instr_word, predriver_feedback;
    mcju_pc_t    jr0, jr1, pc, epc;
    int          miscompares, checked, seed = 32'h543C;
    mcju_top mcju_top_i (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_valid, .instr_word, .predriver_feedback,
        .jump_register_set0(jr0), .jump_register_set1(jr1), .micro_program_counter(pc),
        .jump_taken);
    mcju_partner mcju_partner_i (.pc, .instr_word, .jreg0(jr0), .jreg1(jr1));
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic mcju_word_t gen(input logic [31:0] r);
        case (r[17:16])
            2'h0: return {6'h08, r[9:0]};
            2'h1: return {6'h0E, r[9:4], 4'h4};
            2'h2: return {6'h05, r[9:0]};
            default: return {6'h0E, r[9:4], 4'h5};
        endcase
    endfunction
    task automatic apb(input logic w, input mcju_addr_t a, input logic [31:0] wd,
                       input logic [32:0] exp);
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        if (!w) qa.push_back(exp);
        @(posedge core_clk);
        penable <= 1'h1;
        do begin @(posedge core_clk); end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic run(input int n);
        mcju_word_t w, fb;
        logic       tk;
        mcju_pc_t   nx;
        repeat (n) begin
            @(posedge core_clk);
            fb = 16'($random(seed));
            instr_valid <= 1'h1;
            predriver_feedback <= fb;
            w = mcju_partner_i.code_ram[epc];
            nx = epc + {{5{w[4]}}, w[4:0]};
            tk = 1'h0;
            if (w[15:10] == 6'h08) tk = ctrl[cfg][w[8:5]] == w[9];
            if (w[15:10] == 6'h05) tk = fb[w[9:6]] == w[5];
            if (w[15:10] == 6'h0E && w[3:0] == 4'h4) begin
                tk = fb[w[9:6]] == w[5];
                nx = w[4] ? jr1 : jr0;
            end
            if (!tk) nx = epc + 10'h001;
            qi.push_back({tk, nx});
            epc = nx;
        end
        @(posedge core_clk);
        instr_valid <= 1'h0;
    endtask
    always @(posedge core_clk) begin
        if (pready === 1'h1 && pwrite === 1'h0) check("apb read", {pslverr, prdata}, qa.pop_front());
        if (instr_valid === 1'h1 && rst === 1'h0) begin
            #1;
            check("step", {22'h0, jump_taken, pc}, {22'h0, qi.pop_front()});
        end
    end
    initial begin
        #40000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        rst = 1'h1;
        {psel, penable, pwrite, instr_valid} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        predriver_feedback = 16'h0000;
        for (int a = 0; a < 1024; a++) mcju_partner_i.code_ram[a] = gen($random(seed));
        for (int j = 0; j < 2; j++) mcju_partner_i.jregs[j] = 10'($random(seed));
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        apb(1'h0, 12'h004, 32'h0, 33'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, ra[i], 32'h0, 33'h0);
            d = $random(seed);
            ctrl[i] = d[15:0];
            apb(1'h1, ra[i], d, 33'h0);
            apb(1'h0, ra[i], 32'h0, {17'h0, d[15:0]});
        end
        apb(1'h0, 12'h008, 32'h0, {1'h1, 32'h0});
        apb(1'h0, 12'h405, 32'h0, {1'h1, 32'h0});
        for (int c = 0; c < 4; c++) begin
            cfg = c[1:0];
            apb(1'h1, 12'h000, 32'(c), 33'h0);
            apb(1'h0, 12'h000, 32'h0, {31'h0, cfg});
            d = $random(seed);
            epc = d[9:0];
            apb(1'h1, 12'h004, d, 33'h0);
            run(200);
        end
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        check("reset", {22'h0, jump_taken, pc}, 33'h0);
        apb(1'h0, 12'h000, 32'h0, 33'h0);
        apb(1'h0, ra[3], 32'h0, 33'h0);
        cfg = 2'h0;
        ctrl = '{default: 16'h0000};
        epc = 10'h000;
        run(20);
        report_and_stop();
    end
endmodule // mcju_tb
